// ===== pse_status_enc.sv
// pse_status_enc: four-bit execution status code driven from the execution unit
// assumes event inputs are synchronous one-cycle pulses from the execution core
`timescale 1ns/1ns
// Notes on behaviour
// - status outputs change on the clock, independent of bus transfers
// - state codes carry no pipe stage and hold while the state lasts
// - default code is 0 in user state, 8 in supervisor state
// - completion codes last one clock per instruction, never two at once
// - user codes: 0 run, 1 end, 2 not taken, 3 taken, 4 table
// - supervisor codes: 8 run, 9 end, A not taken, B taken, C table
// - 5 halted, D stopped, E exception return running, F stacking
// - 6 low-power stop only on low-voltage variant; 7 never driven
// - taken code means flow change; stacking always ends with code B
// - flow-changing and serialising instructions end with the taken code
// - only integer not-taken branches give not-taken; float one gives end
// - other instructions end plainly; back-to-back ends hold the end code
// - access error before execute: no end code, stacking then B
// - float trap not trapping ends plainly; trapping shows stacking then B
// - two interrupts: end, stacking, B, run code, stacking, B
// - exception return after an instruction: end, E, then taken code
// - reset clears the status outputs
module pse_status_enc
  import pse_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
)
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  supervisor,
  input  wire logic                  instr_done,
  input  pse_pkg::pse_ins_t          instr_kind,
  input  wire logic                  exc_start,
  input  wire logic                  exc_done,
  input  wire logic                  excret_done,
  input  wire logic                  table_busy,
  input  wire logic                  stop_enter,
  input  wire logic                  lpstop_enter,
  input  wire logic                  wake,
  input  wire logic                  double_fault,
  output logic [3:0]                 exec_state_code
);
  import pse_pkg::*;

  // ----------------------------------------------------------------
  // instruction classification
  // ----------------------------------------------------------------
  pse_state_t state_r;
  pse_state_t state_nxt;
  logic       taken_w;
  logic       not_taken_w;
  logic       is_excret_w;
  logic       end_pulse_w;
  logic       exc_bt_w;
  logic [3:0] code_nxt;
  logic [3:0] code_r;

  assign taken_w     = (instr_kind == PSE_INS_FLOW);
  assign not_taken_w = (instr_kind == PSE_INS_COND_NT);
  assign is_excret_w = (instr_kind == PSE_INS_EXC_RETURN);
  // an exception return shows its plain end first, then E, then taken
  assign end_pulse_w = instr_done && (state_r == PSE_ST_RUN);
  // stacking finishes like a virtual jump, always in supervisor encoding
  assign exc_bt_w    = ((state_r == PSE_ST_STACK) && exc_done) ||
                       ((state_r == PSE_ST_EXCRET) && excret_done);

  // ----------------------------------------------------------------
  // persistent state tracking
  // ----------------------------------------------------------------
  // halt is sticky until reset; a double fault preempts everything else
  always_comb begin
    state_nxt = state_r;
    if (double_fault) begin
      state_nxt = PSE_ST_HALTED;
    end else begin
      unique case (state_r)
        PSE_ST_RUN: begin
          if (exc_start)                 state_nxt = PSE_ST_STACK;
          else if (instr_done && is_excret_w)
                                          state_nxt = PSE_ST_EXCRET;
          else if (stop_enter)            state_nxt = PSE_ST_STOPPED;
          else if (lpstop_enter && LOW_VOLTAGE)
                                          state_nxt = PSE_ST_LPSTOP;
          else if (table_busy)            state_nxt = PSE_ST_TABLE;
        end
        PSE_ST_STACK:   if (exc_done)    state_nxt = PSE_ST_RUN;
        PSE_ST_EXCRET:  if (excret_done) state_nxt = PSE_ST_RUN;
        PSE_ST_TABLE: begin
          if (exc_start)                 state_nxt = PSE_ST_STACK;
          else if (!table_busy)          state_nxt = PSE_ST_RUN;
        end
        PSE_ST_STOPPED, PSE_ST_LPSTOP: begin
          // an interrupt wakes the core by stacking
          if (exc_start)                 state_nxt = PSE_ST_STACK;
          else if (wake)                 state_nxt = PSE_ST_RUN;
        end
        PSE_ST_HALTED:                   state_nxt = PSE_ST_HALTED;
        default:                         state_nxt = PSE_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // code selection
  // ----------------------------------------------------------------
  pse_code_mux u_mux (
    .supervisor    (supervisor),
    .state         (state_r),
    .end_pulse     (end_pulse_w),
    .end_taken     (taken_w),
    .end_not_taken (not_taken_w),
    .exc_bt        (exc_bt_w),
    .code          (code_nxt)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= PSE_ST_RUN;
      code_r  <= CODE_RESET_VAL;
    end else begin
      state_r <= state_nxt;
      code_r  <= code_nxt;
    end
  end

  assign exec_state_code = code_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_stack_end;
    exc_done && (state_r == PSE_ST_STACK);
  endsequence

  a_code_registered: assert property (1'b1 |=> exec_state_code == $past(code_nxt))
    else $error("status code not registered");
  a_never_reserved: assert property (exec_state_code != CODE_RESERVED)
    else $error("reserved code driven");
  a_lpstop_variant: assert property (!LOW_VOLTAGE |-> exec_state_code != CODE_LP_STOP)
    else $error("low-power code on standard variant");
  a_stack_then_bt: assert property (s_stack_end |=> exec_state_code == CODE_SUP_BT)
    else $error("stacking not ended by supervisor taken");
  a_stack_shown: assert property (state_r == PSE_ST_STACK && !exc_done
                                  |=> exec_state_code == CODE_STACKING)
    else $error("stacking code missing");
  a_halt_holds: assert property (double_fault |=> ##1 exec_state_code == CODE_HALTED [*4])
    else $error("halted code not held");
  a_plain_end: assert property (instr_done && state_r == PSE_ST_RUN
                                && instr_kind == PSE_INS_FLOAT_NT && !exc_bt_w
                                |=> exec_state_code[2:0] == CODE_USR_END[2:0])
    else $error("float not-taken did not end plainly");
  a_taken_end: assert property (instr_done && state_r == PSE_ST_RUN && taken_w
                                |=> exec_state_code[1:0] == OFS_BT[1:0])
    else $error("flow instruction did not end taken");
  a_nt_end: assert property (instr_done && state_r == PSE_ST_RUN && not_taken_w
                             |=> exec_state_code[1:0] == OFS_BNT[1:0])
    else $error("branch not taken code missing");
  // the return may finish on its first cycle, which shows B at once instead of E
  a_excret_seq: assert property (instr_done && state_r == PSE_ST_RUN && is_excret_w
                                 && !exc_start && !double_fault ##1 !excret_done
                                 |=> exec_state_code == CODE_EXC_RET)
    else $error("exception return code missing");
  a_default_run: assert property (state_r == PSE_ST_RUN && !instr_done && !double_fault
                                  |=> exec_state_code == {$past(supervisor), 3'b000})
    else $error("default run code wrong");
endmodule // pse_status_enc

// ===== pse_pkg.sv
// package for the execution status encoder: status codes, event kinds, fsm states
// assumes nothing beyond a SystemVerilog-2012 compiler
package pse_pkg;

  localparam int PSE_CODE_W = 4;

  // ----------------------------------------------------------------
  // status codes shown on the four status outputs
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_USR_RUN   = 4'h0;
  localparam logic [3:0] CODE_USR_END   = 4'h1;
  localparam logic [3:0] CODE_USR_BNT   = 4'h2;
  localparam logic [3:0] CODE_USR_BT    = 4'h3;
  localparam logic [3:0] CODE_USR_TBL   = 4'h4;
  localparam logic [3:0] CODE_HALTED    = 4'h5;
  localparam logic [3:0] CODE_LP_STOP   = 4'h6;
  localparam logic [3:0] CODE_RESERVED  = 4'h7;
  localparam logic [3:0] CODE_SUP_RUN   = 4'h8;
  localparam logic [3:0] CODE_SUP_END   = 4'h9;
  localparam logic [3:0] CODE_SUP_BNT   = 4'hA;
  localparam logic [3:0] CODE_SUP_BT    = 4'hB;
  localparam logic [3:0] CODE_SUP_TBL   = 4'hC;
  localparam logic [3:0] CODE_STOPPED   = 4'hD;
  localparam logic [3:0] CODE_EXC_RET   = 4'hE;
  localparam logic [3:0] CODE_STACKING  = 4'hF;
  localparam logic [3:0] CODE_RESET_VAL = 4'h0;

  // supervisor bit of a code, and offsets of the end and table codes from the run code
  localparam int          CODE_SUP_BIT  = 3;
  localparam logic [3:0]  OFS_END       = 4'h1;
  localparam logic [3:0]  OFS_BNT       = 4'h2;
  localparam logic [3:0]  OFS_BT        = 4'h3;
  localparam logic [3:0]  OFS_TBL       = 4'h4;

  // ----------------------------------------------------------------
  // kind of instruction reported at its last execution stage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSE_INS_PLAIN      = 3'h0,  // ordinary instruction
    PSE_INS_FLOW       = 3'h1,  // taken branch, jump, call, return, sr write, movec, cas ...
    PSE_INS_COND_NT    = 3'h2,  // conditional branch or decrement_branch_loop not taken
    PSE_INS_FLOAT_NT   = 3'h3,  // float_conditional_branch not taken
    PSE_INS_FTRAP_NT   = 3'h4,  // float_conditional_trap that does not trap
    PSE_INS_EXC_RETURN = 3'h5   // exception_return_instr
  } pse_ins_t;

  // ----------------------------------------------------------------
  // persistent processor states, gray along run->stack->...
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSE_ST_RUN     = 3'b000,
    PSE_ST_STACK   = 3'b001,
    PSE_ST_EXCRET  = 3'b011,
    PSE_ST_TABLE   = 3'b010,
    PSE_ST_STOPPED = 3'b110,
    PSE_ST_HALTED  = 3'b111,
    PSE_ST_LPSTOP  = 3'b101
  } pse_state_t;

endpackage : pse_pkg

// ===== pse_code_mux.sv
// pse_code_mux: combinational choice of the next status code
// assumes the caller registers the result; no state of its own
`timescale 1ns/1ns
module pse_code_mux
  import pse_pkg::*;
(
  input  wire logic             supervisor,
  input  pse_pkg::pse_state_t   state,
  input  wire logic             end_pulse,
  input  wire logic             end_taken,
  input  wire logic             end_not_taken,
  input  wire logic             exc_bt,
  output logic [3:0]            code
);
  import pse_pkg::*;

  logic [3:0] base_w;
  logic [3:0] end_w;
  logic [3:0] state_w;

  assign base_w = supervisor ? CODE_SUP_RUN : CODE_USR_RUN;
  // one completion code at a time: taken beats not taken beats plain end
  assign end_w  = exc_bt        ? CODE_SUP_BT :
                  end_taken     ? (base_w | OFS_BT) :
                  end_not_taken ? (base_w | OFS_BNT) :
                                  (base_w | OFS_END);

  always_comb begin
    unique case (state)
      PSE_ST_STACK:   state_w = CODE_STACKING;
      PSE_ST_EXCRET:  state_w = CODE_EXC_RET;
      PSE_ST_TABLE:   state_w = base_w | OFS_TBL;
      PSE_ST_STOPPED: state_w = CODE_STOPPED;
      PSE_ST_HALTED:  state_w = CODE_HALTED;
      PSE_ST_LPSTOP:  state_w = CODE_LP_STOP;
      default:        state_w = base_w;
    endcase
  end

  assign code = (end_pulse || exc_bt) ? end_w : state_w;
endmodule // pse_code_mux

// ===== pse_trace_mon.sv
// pse_trace_mon: far-side trace probe counting completion codes it sees
// assumes it samples the status code on the core's rising clock edge
`timescale 1ns/1ns
module pse_trace_mon (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] exec_state_code,
  output int              n_end
);
  // ----------------------------------------------------------------
  // completion codes 1,2,3,9,a,b: one count per clock shown
  // ----------------------------------------------------------------
  wire logic is_end = !exec_state_code[2] && (exec_state_code[1:0] != 2'b00);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n_end <= 0;
    end else if (is_end) begin
      n_end <= n_end + 1;
    end
  end
endmodule // pse_trace_mon

// ===== pse_status_enc_test.sv
// pse_status_enc_test: random state-aware stimulus against a cycle model
// assumes the low-voltage build so that code 6 can be reached
`timescale 1ns/1ns
module pse_status_enc_test;
  import pse_pkg::*;
  logic       clk, rstn, supervisor, instr_done, exc_start, exc_done, excret_done;
  logic       table_busy, stop_enter, lpstop_enter, wake, double_fault;
  pse_ins_t   instr_kind;
  logic [3:0] exec_state_code, exp_code;
  pse_state_t st;
  int         n_mismatch, checks_done, cyc, n_end, n_exp_end;
  int         seed = 32'h7dde2d74;

  pse_status_enc #(.LOW_VOLTAGE(1'b1)) pse_status_enc_inst (.clk, .rstn, .supervisor,
    .instr_done, .instr_kind, .exc_start, .exc_done, .excret_done, .table_busy,
    .stop_enter, .lpstop_enter, .wake, .double_fault, .exec_state_code);
  pse_trace_mon pse_trace_mon_inst (.clk, .rstn, .exec_state_code, .n_end);

  // ----------------------------------------------------------------
  // reference model: code at edge n+1 from state and inputs at edge n
  // ----------------------------------------------------------------
  task automatic step();
    logic [3:0] b;
    logic [3:0] c;
    pse_state_t n;
    b = supervisor ? CODE_SUP_RUN : CODE_USR_RUN;
    c = b;
    n = st;
    case (st)
      PSE_ST_RUN: begin
        if (instr_done) begin
          c = b + ((instr_kind == PSE_INS_FLOW) ? OFS_BT :
                   (instr_kind == PSE_INS_COND_NT) ? OFS_BNT : OFS_END);
          if (instr_kind == PSE_INS_EXC_RETURN) n = PSE_ST_EXCRET;
        end
        if (exc_start) n = PSE_ST_STACK;
        else if (stop_enter) n = PSE_ST_STOPPED;
        else if (lpstop_enter) n = PSE_ST_LPSTOP;
        else if (table_busy) n = PSE_ST_TABLE;
      end
      PSE_ST_STACK: begin
        c = exc_done ? CODE_SUP_BT : CODE_STACKING;
        if (exc_done) n = PSE_ST_RUN;
      end
      PSE_ST_EXCRET: begin
        c = excret_done ? CODE_SUP_BT : CODE_EXC_RET;
        if (excret_done) n = PSE_ST_RUN;
      end
      PSE_ST_TABLE: begin
        c = b + OFS_TBL;
        if (!table_busy) n = PSE_ST_RUN;
      end
      PSE_ST_STOPPED: begin
        c = CODE_STOPPED;
        if (exc_start) n = PSE_ST_STACK;
        else if (wake) n = PSE_ST_RUN;
      end
      PSE_ST_LPSTOP: begin
        c = CODE_LP_STOP;
        if (wake) n = PSE_ST_RUN;
      end
      default: c = CODE_HALTED;
    endcase
    if (double_fault) n = PSE_ST_HALTED;
    exp_code = c;
    st = n;
  endtask

  // events chosen to suit the model state; combinations left open are avoided
  task automatic drive(input bit df);
    int k;
    logic id, xs, xd, xr, tb, sp, lp, wk;
    pse_ins_t kd;
    k = $unsigned($random(seed)) % 8;
    kd = pse_ins_t'($unsigned($random(seed)) % 6);
    {id, xs, xd, xr, tb, sp, lp, wk} = 8'h00;
    case (st)
      PSE_ST_RUN: begin
        id = (k < 2) || (k == 3);
        xs = (k == 2) || (k == 3);
        sp = (k == 4);
        lp = (k == 5);
        tb = (k == 6);
      end
      PSE_ST_STACK: xd = (k < 3);
      PSE_ST_EXCRET: xr = (k < 3);
      PSE_ST_TABLE: {tb, id} = {k < 5, k[0]};
      PSE_ST_STOPPED: {wk, xs} = {k < 2, k == 2};
      PSE_ST_LPSTOP: wk = (k < 2);
      default: {id, xs, wk} = k[2:0];
    endcase
    if (xs) kd = PSE_INS_PLAIN;
    if (df) {id, xs, xd, xr, tb, sp, lp, wk} = 8'h00;
    supervisor <= $random(seed);
    instr_kind <= kd;
    {instr_done, exc_start, exc_done, excret_done} <= {id, xs, xd, xr};
    {table_busy, stop_enter, lpstop_enter, wake, double_fault} <= {tb, sp, lp, wk, df};
  endtask

  task automatic compare_code(input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic compare_count(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: count expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, stimulus and per-cycle comparison
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rstn, supervisor, instr_done, exc_start, exc_done, excret_done} = 6'h00;
    {table_busy, stop_enter, lpstop_enter, wake, double_fault} = 5'h00;
    instr_kind = PSE_INS_PLAIN;
    exp_code = CODE_RESET_VAL;
    st = PSE_ST_RUN;
    wait (cyc == 2300);
    @(negedge clk);
    compare_count(n_exp_end, n_end);
    report_and_stop();
  end

  always @(posedge clk) begin
    compare_code(rstn ? exp_code : CODE_RESET_VAL, exec_state_code);
    if (rstn && !exp_code[2] && exp_code[1:0] != 2'b00) n_exp_end++;
    if (!rstn) begin
      st = PSE_ST_RUN;
      exp_code = CODE_RESET_VAL;
      n_exp_end = 0;
    end else begin
      step();
    end
    rstn <= !(cyc < 5 || (cyc >= 1600 && cyc < 1603));
    drive(cyc == 1500);
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
    cyc = cyc + 1;
  end
endmodule // pse_status_enc_test
